// ===== design/cise_core.sv
// Decode and execute logic for a subset of the 14-bit instruction set.
//
// Notes on behaviour
// RULE1: Bit test skips next when selected bit set.
// RULE2: Taken skip flushes fetched word, runs a no-op.
// RULE3: Call uses 11-bit target, two cycles, no flags.
// RULE4: Call pushes incremented PC onto stack top.
// RULE5: Call loads PC low bits, latch bits high.
// RULE6: Clear writes zero to register, sets zero flag.
// RULE7: Swap exchanges nibbles, flags unchanged.
// RULE8: Destination bit picks accumulator or file register.
// RULE9: Direction load copies accumulator, selector five..seven.
// RULE10: Literal XOR into accumulator, updates zero flag.
// RULE11: File XOR, destination selectable, updates zero flag.
// RULE12: Zero flag set exactly when result zero.
// RULE13: Other opcodes leave this block's state untouched.
`timescale 1ns/1ps
`default_nettype none
`include "cise_regs.svh"

module cise_core
(
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            instr_valid,
    input  wire logic [13:0]     instr_word,
    input  wire logic [12:0]     pc_current,
    input  wire logic [7:0]      file_rdata,
    input  wire logic [7:0]      pc_high_latch,
    output var  logic [6:0]      file_addr,
    output var  logic [7:0]      file_wdata,
    output var  logic            file_we,
    output var  logic [7:0]      w_reg,
    output var  logic            zero_flag,
    output var  logic            pc_load,
    output var  logic [12:0]     pc_target,
    output var  logic            stack_push,
    output var  logic [12:0]     stack_top,
    output var  logic            flush,
    output var  logic            busy,
    output var  logic [7:0]      dir_a,
    output var  logic [7:0]      dir_b,
    output var  logic [7:0]      dir_c,
    output var  logic            cise_state_flush
);
    import cise_pkg::*;

    // ****************************************************************
    // Timing overview
    // ****************************************************************

    // One word is taken per rising edge while instr_valid is high and no
    // flush slot is running. Every result appears on the outputs one edge
    // after its word was taken, so the fetch side sees a fixed latency.
    //
    // A taken skip or a call claims one extra cycle. The word presented in
    // that cycle is the one already fetched behind the skip or call, and it
    // is dropped here rather than by the fetch side, which keeps the fetch
    // logic free of any knowledge of instruction classes.
    //
    // The file address is driven straight from the instruction word so the
    // read data returns in the same cycle. Writes leave one cycle later, so
    // the file space must hold on to the address of the originating word.
    // Limitation: a word that reads a register written by the word just
    // before it sees the old value unless the file space forwards the write.

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************

    // A pattern bit outside its mask could never match, which would
    // silently turn an instruction into a no-op.
    if (((`CISE_PAT_BTSS & ~`CISE_MASK_BTSS) | (`CISE_PAT_CALL & ~`CISE_MASK_CALL)
         | (`CISE_PAT_CLR & ~`CISE_MASK_CLR) | (`CISE_PAT_SWAP & ~`CISE_MASK_SWAP)
         | (`CISE_PAT_XORL & ~`CISE_MASK_XORL) | (`CISE_PAT_XORF & ~`CISE_MASK_XORF)
         | (`CISE_PAT_DIR & ~`CISE_MASK_DIR)) != 14'h0000)
    begin : g_bad_pattern
        $error("Opcode pattern lies outside its mask.");
    end

    // The direction decode needs a selector range that is not empty.
    if (`CISE_DIR_MIN > `CISE_DIR_MAX)
    begin : g_bad_dir_range
        $error("Direction selector range is empty.");
    end

    // ****************************************************************
    // Decode
    // ****************************************************************

    // Classifies one instruction word; unknown words fall to no-op.
    function automatic cise_op_t decode_op(input logic [13:0] w);
        decode_op = CISE_OP_NONE;
        if ((w & `CISE_MASK_BTSS) == `CISE_PAT_BTSS)      decode_op = CISE_OP_BTSS;
        else if ((w & `CISE_MASK_CALL) == `CISE_PAT_CALL) decode_op = CISE_OP_CALL;
        else if ((w & `CISE_MASK_CLR) == `CISE_PAT_CLR)   decode_op = CISE_OP_CLR;
        else if ((w & `CISE_MASK_SWAP) == `CISE_PAT_SWAP) decode_op = CISE_OP_SWAP;
        else if ((w & `CISE_MASK_XORL) == `CISE_PAT_XORL) decode_op = CISE_OP_XORL;
        else if ((w & `CISE_MASK_XORF) == `CISE_PAT_XORF) decode_op = CISE_OP_XORF;
        else if ((w & `CISE_MASK_DIR) == `CISE_PAT_DIR
                 && w[2:0] >= `CISE_DIR_MIN && w[2:0] <= `CISE_DIR_MAX)
            decode_op = CISE_OP_DIR;
    endfunction

    // Zero test used by both XOR results; clear sets the flag directly.
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == `CISE_RST_BYTE); // RULE12
    endfunction

    // True when the word just taken claims the next cycle as a flush slot.
    // Shared by the state register and the slot indicators so that they
    // can never disagree about which words burn a cycle.
    function automatic logic takes_slot(input cise_op_t o, input logic [7:0] v,
                                        input logic [2:0] idx);
        takes_slot = (o == CISE_OP_BTSS && v[idx]) // RULE1
                     || o == CISE_OP_CALL; // RULE3
    endfunction

    cise_state_t state_q;
    cise_op_t    op;
    logic        exec;
    logic        dest_file;
    logic [2:0]  bit_idx;
    logic [7:0]  swapped;
    logic [7:0]  xored_f;
    logic [7:0]  xored_l;
    logic [7:0]  literal;
    logic [10:0] call_k;
    logic [2:0]  dir_sel;

    // A word arriving while the flush slot runs is the discarded one.
    assign exec      = instr_valid && (state_q == CISE_ST_EXEC);
    assign op        = exec ? decode_op(instr_word) : CISE_OP_NONE; // RULE13
    assign dest_file = instr_word[`CISE_DBIT];
    assign bit_idx   = instr_word[`CISE_BIT_LSB +: 3];
    assign swapped   = {file_rdata[3:0], file_rdata[7:4]}; // RULE7
    assign xored_f   = w_reg ^ file_rdata; // RULE11
    assign xored_l   = w_reg ^ literal; // RULE10

    // Operand fields of the current word, named once for every consumer.
    assign literal   = instr_word[7:0];
    assign call_k    = instr_word[10:0];
    assign dir_sel   = instr_word[2:0];

    // Address to the file space is combinational so reads land same cycle.
    assign file_addr = instr_word[6:0];

    // ****************************************************************
    // Sequencing
    // ****************************************************************

    // Both a taken skip and a call burn one extra flush cycle.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_q <= CISE_ST_EXEC;
        else
            case (state_q)
                CISE_ST_EXEC:
                begin
                    // The word behind a taken skip or call is already fetched.
                    if (takes_slot(op, file_rdata, bit_idx))
                        state_q <= CISE_ST_FLUSH; // RULE2
                end
                // The slot lasts exactly one cycle; the word in it is dropped.
                CISE_ST_FLUSH: state_q <= CISE_ST_EXEC;
                default:       state_q <= CISE_ST_EXEC;
            endcase
    end

    // Flush and busy mirror the state register one for one.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flush            <= 1'b0;
            busy             <= 1'b0;
            cise_state_flush <= 1'b0;
        end
        else
        begin
            flush            <= takes_slot(op, file_rdata, bit_idx); // RULE2
            busy             <= takes_slot(op, file_rdata, bit_idx);
            cise_state_flush <= takes_slot(op, file_rdata, bit_idx);
        end
    end

    // ****************************************************************
    // Call: push and program counter load
    // ****************************************************************

    // The return address goes out with the push, in the same cycle as the new PC loads.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stack_push <= 1'b0;
            stack_top  <= `CISE_RST_PC;
            pc_load    <= 1'b0;
            pc_target  <= `CISE_RST_PC;
        end
        else
        begin
            stack_push <= (op == CISE_OP_CALL);
            pc_load    <= (op == CISE_OP_CALL);
            if (op == CISE_OP_CALL)
            begin
                // Both values are taken at the same edge, so the return
                // address never sees the new program counter.
                stack_top <= 13'(pc_current + `CISE_PC_STEP); // RULE4
                // Only two latch bits reach the counter; the rest are
                // ignored, so a call cannot leave the 13-bit space.
                pc_target <= {pc_high_latch[`CISE_LATCH_HI:`CISE_LATCH_LO],
                              call_k}; // RULE5
            end
        end
    end

    // ****************************************************************
    // File write port
    // ****************************************************************

    // Results bound for the file register go out as a one-cycle write.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            file_we    <= 1'b0;
            file_wdata <= `CISE_RST_BYTE;
        end
        else
        begin
            file_we <= 1'b0;
            case (op)
                // Clear has no destination bit; it always writes the file.
                CISE_OP_CLR:
                begin
                    file_we    <= 1'b1;
                    file_wdata <= `CISE_RST_BYTE; // RULE6
                end
                CISE_OP_SWAP:
                begin
                    file_we    <= dest_file; // RULE8
                    file_wdata <= swapped;
                end
                CISE_OP_XORF:
                begin
                    file_we    <= dest_file; // RULE8
                    file_wdata <= xored_f;
                end
                default: file_we <= 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // Accumulator and zero flag
    // ****************************************************************

    // Accumulator takes results whose destination bit is clear.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            w_reg <= `CISE_RST_BYTE;
        else
            case (op)
                CISE_OP_SWAP: if (!dest_file) w_reg <= swapped; // RULE8
                CISE_OP_XORF: if (!dest_file) w_reg <= xored_f; // RULE11
                CISE_OP_XORL: w_reg <= xored_l; // RULE10
                default:      w_reg <= w_reg;
            endcase
    end

    // Swap, call, skip and direction load leave the flag alone.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            zero_flag <= 1'b0;
        else
            case (op)
                CISE_OP_CLR:  zero_flag <= 1'b1; // RULE6
                CISE_OP_XORF: zero_flag <= is_zero(xored_f); // RULE12
                CISE_OP_XORL: zero_flag <= is_zero(xored_l); // RULE12
                default:      zero_flag <= zero_flag;
            endcase
    end

    // ****************************************************************
    // Port direction registers
    // ****************************************************************

    // Resetting to all ones leaves every pin an input until software acts.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dir_a <= `CISE_DIR_RST;
            dir_b <= `CISE_DIR_RST;
            dir_c <= `CISE_DIR_RST;
        end
        // Selectors below the range never get here; decode refuses them.
        else if (op == CISE_OP_DIR)
            case (dir_sel) // RULE9
                `CISE_SEL_A: dir_a <= w_reg;
                `CISE_SEL_B: dir_b <= w_reg;
                `CISE_SEL_C: dir_c <= w_reg;
                default:     dir_a <= dir_a;
            endcase
    end
endmodule

`default_nettype wire

// ===== include/cise_pkg.sv
// Types shared by the instruction subset executor.
`default_nettype none
package cise_pkg;
    typedef enum logic [1:0]
    {
        CISE_ST_EXEC  = 2'h0,
        CISE_ST_FLUSH = 2'h1
    } cise_state_t;

    typedef enum logic [2:0]
    {
        CISE_OP_NONE = 3'h0,
        CISE_OP_BTSS = 3'h1,
        CISE_OP_CALL = 3'h2,
        CISE_OP_CLR  = 3'h3,
        CISE_OP_SWAP = 3'h4,
        CISE_OP_DIR  = 3'h5,
        CISE_OP_XORL = 3'h6,
        CISE_OP_XORF = 3'h7
    } cise_op_t;
endpackage
`default_nettype wire

// ===== include/cise_regs.svh
// Encoding and layout constants for the instruction subset executor.
`ifndef CISE_REGS_SVH
`define CISE_REGS_SVH

`define CISE_MASK_BTSS   14'h3C00
`define CISE_PAT_BTSS    14'h1C00
`define CISE_MASK_CALL   14'h3800
`define CISE_PAT_CALL    14'h2000
`define CISE_MASK_CLR    14'h3F80
`define CISE_PAT_CLR     14'h0180
`define CISE_MASK_SWAP   14'h3F00
`define CISE_PAT_SWAP    14'h0E00
`define CISE_MASK_DIR    14'h3FF8
`define CISE_PAT_DIR     14'h0060
`define CISE_MASK_XORL   14'h3F00
`define CISE_PAT_XORL    14'h3A00
`define CISE_MASK_XORF   14'h3F00
`define CISE_PAT_XORF    14'h0600
`define CISE_DBIT        7
`define CISE_BIT_LSB     7
`define CISE_DIR_MIN     3'h5
`define CISE_DIR_MAX     3'h7
`define CISE_SEL_A       3'h5
`define CISE_SEL_B       3'h6
`define CISE_SEL_C       3'h7
`define CISE_PC_STEP     13'h0001
`define CISE_LATCH_HI    4
`define CISE_LATCH_LO    3
`define CISE_RST_BYTE    8'h00
`define CISE_RST_PC      13'h0000
`define CISE_DIR_RST     8'hFF

`endif

// ===== tb/cise_file_mdl.sv
// Data file register space seen from the executor.
`timescale 1ns/1ps
`default_nettype none
module cise_file_mdl
(
    input  wire logic       clk,
    input  wire logic [6:0] file_addr,
    input  wire logic       file_we,
    input  wire logic [7:0] file_wdata,
    output var  logic [7:0] file_rdata
);
    logic [7:0] mem [128];
    logic [6:0] addr_q;
    // A known pattern lets the bench recompute every read.
    initial
    begin
        for (int i = 0; i < 128; i++)
        begin
            mem[i] = 8'h5A ^ 8'(i);
        end
    end
    assign file_rdata = mem[file_addr];
    // The write comes a cycle late, so it lands at the latched address.
    always @(posedge clk)
    begin
        addr_q <= file_addr;
        if (file_we)
        begin
            mem[addr_q] <= file_wdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/cise_props.sv
// Port checks for the instruction subset executor.
`timescale 1ns/1ps
`default_nettype none
`include "cise_regs.svh"
module cise_props
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [12:0] pc_current,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  pc_high_latch,
    input wire logic [7:0]  file_wdata,
    input wire logic        file_we,
    input wire logic [7:0]  w_reg,
    input wire logic        zero_flag,
    input wire logic        pc_load,
    input wire logic [12:0] pc_target,
    input wire logic        stack_push,
    input wire logic [12:0] stack_top,
    input wire logic        flush,
    input wire logic [7:0]  dir_a
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // A word in the discarded slot after a skip or call is never taken.
    wire logic tk = instr_valid && !flush;
    wire logic is_call = tk && (instr_word & `CISE_MASK_CALL) == `CISE_PAT_CALL;
    wire logic is_skip = tk && (instr_word & `CISE_MASK_BTSS) == `CISE_PAT_BTSS;
    wire logic is_clr = tk && (instr_word & `CISE_MASK_CLR) == `CISE_PAT_CLR;
    wire logic is_swap = tk && (instr_word & `CISE_MASK_SWAP) == `CISE_PAT_SWAP;
    wire logic is_xl = tk && (instr_word & `CISE_MASK_XORL) == `CISE_PAT_XORL;
    wire logic is_xf = tk && (instr_word & `CISE_MASK_XORF) == `CISE_PAT_XORF;
    wire logic is_dir = tk && instr_word == 14'h0065;
    wire logic bsel = file_rdata[instr_word[9:7]];
    wire logic is_dirx = tk && (instr_word & `CISE_MASK_DIR) == `CISE_PAT_DIR
                         && instr_word[2:0] >= 3'h5;
    // A taken word that no decode of this block claims.
    wire logic is_other = tk && !(is_call || is_skip || is_clr || is_swap
                                  || is_xl || is_xf || is_dirx);
    a_call_push: assert property (is_call |=> stack_push && stack_top == $past(pc_current) + 13'h1)
        else $error("call return address wrong");
    a_call_target: assert property (is_call |=> pc_load
        && pc_target == {$past(pc_high_latch[4:3]), $past(instr_word[10:0])})
        else $error("call target wrong");
    a_call_slot: assert property (is_call |=> flush && $stable(zero_flag) ##1 !flush)
        else $error("call timing wrong");
    a_skip_taken: assert property (is_skip && bsel |=> flush && !file_we)
        else $error("taken skip wrong");
    a_skip_not: assert property (is_skip && !bsel |=> !flush && $stable(zero_flag))
        else $error("untaken skip wrong");
    a_clear_zero: assert property (is_clr |=> file_we && file_wdata == 8'h00 && zero_flag)
        else $error("clear wrong");
    a_swap_flags: assert property (is_swap |=> $stable(zero_flag))
        else $error("swap touched flag");
    a_xor_lit: assert property (is_xl |=> w_reg == ($past(w_reg) ^ $past(instr_word[7:0]))
        && zero_flag == (w_reg == 8'h00))
        else $error("literal xor wrong");
    a_xor_dest: assert property (is_xf |=> file_we == $past(instr_word[7]))
        else $error("xor destination wrong");
    a_dir_load: assert property (is_dir |=> dir_a == $past(w_reg))
        else $error("direction load wrong");
    a_foreign_quiet: assert property (is_other |=> !file_we && !pc_load && !flush
        && $stable(w_reg) && $stable(zero_flag))
        else $error("foreign word changed state");
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the instruction subset executor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic resetn, instr_valid, file_we, zero_flag, pc_load, stack_push, flush;
    logic busy, cise_state_flush;
    logic [13:0] instr_word;
    logic [12:0] pc_current, pc_target, stack_top;
    logic [7:0] pc_high_latch, file_rdata, file_wdata, w_reg, dir_a, dir_b, dir_c;
    logic [6:0] file_addr;
    int failures = 0;
    int compares = 0;
    cise_core dut (.*);
    cise_file_mdl mdl (.*);
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
        compares++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One word per cycle; results are settled at the next falling edge.
    task automatic exec(input logic [13:0] w);
        instr_word = w;
        @(negedge clk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_xor;
        exec(14'h3AB5);
        chk("w", w_reg, 8'hB5);
        exec(14'h3AB5);
        chk("z", zero_flag, 1'b1);
        exec(14'h3AAF);
        exec(14'h060A);
        chk("w", w_reg, 8'hFF);
        chk("we", file_we, 1'b0);
        exec(14'h068B);
        chk("wd", file_wdata, 8'hAE);
        exec(14'h3AFF);
        chk("mem", mdl.mem[11], 8'hAE);
        $display("xor done");
    endtask
    task automatic t_swap_clr;
        exec(14'h0E20);
        chk("w", w_reg, 8'hA7);
        exec(14'h0EA1);
        chk("wd", file_wdata, 8'hB7);
        chk("w", w_reg, 8'hA7);
        exec(14'h3A01);
        exec(14'h01FF);
        chk("z", zero_flag, 1'b1);
        exec(14'h0000);
        chk("mem", mdl.mem[127], 8'h00);
        $display("swap and clear done");
    endtask
    task automatic t_dir;
        for (int s = 5; s < 8; s++)
        begin
            exec(14'h3A00 | 14'(s));
            exec(14'h0060 | 14'(s));
        end
        exec(14'h0064);
        chk("da", dir_a, 8'hA3);
        chk("db", dir_b, 8'hA5);
        chk("dc", dir_c, 8'hA2);
        $display("direction done");
    endtask
    task automatic t_skip_call;
        exec(14'h1E85);
        chk("fl", flush, 1'b0);
        exec(14'h1F05);
        chk("fl", flush, 1'b1);
        chk("busy", busy, 1'b1);
        chk("sfl", cise_state_flush, 1'b1);
        exec(14'h0181);
        chk("we", file_we, 1'b0);
        pc_current = 13'h0123;
        pc_high_latch = 8'h18;
        exec(14'h27FF);
        chk("pt", pc_target, 13'h1FFF);
        chk("st", stack_top, 13'h0124);
        chk("sp", stack_push & pc_load & flush, 1'b1);
        pc_high_latch = 8'hE7;
        exec(14'h3AFF);
        chk("w", w_reg, 8'hA2);
        exec(14'h2001);
        chk("pt", pc_target, 13'h0001);
        // Let the discarded slot pass so the idle word meets a live cycle.
        exec(14'h0000);
        instr_valid = 1'b0;
        exec(14'h0180);
        chk("we", file_we, 1'b0);
        chk("z", zero_flag, 1'b0);
        instr_valid = 1'b1;
        exec(14'h3FFF);
        chk("w", w_reg, 8'hA2);
        $display("skip and call done");
    endtask
    initial
    begin
        resetn = 1'b0;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        pc_current = 13'h0000;
        pc_high_latch = 8'h00;
        repeat (20) @(negedge clk);
        chk("dir reset", dir_c, 8'hFF);
        resetn = 1'b1;
        instr_valid = 1'b1;
        t_xor;
        t_swap_clr;
        t_dir;
        t_skip_call;
        give_verdict;
    end
    // The tests need under a hundred cycles; five thousand means a hang.
    initial
    begin
        #50us;
        failures++;
        give_verdict;
    end
endmodule
bind cise_core cise_props chk (.*);
`default_nettype wire
